// ---- src/scsh_top.sv ----
// controller reset generator with redundant suspend hold latch
`timescale 1ns/1ps
`default_nettype none
module scsh_top (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// device pins and flash
	input wire logic DEVICE_RESET_PIN_N,
	input wire logic TEST_PORT_RESET_N,
	input wire logic HOLD_FEATURE_OFF_BIT,
	// hard ip
	input wire logic CALIBRATION_FINISHED,
	// controller side
	input wire logic [1:0] CTRL_HTRANS,
	input wire logic [7:0] CTRL_OUT_RAW,
	input wire logic PROG_MODE_LOAD,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	// controller control
	output logic CTRL_RESET_N,
	output logic CTRL_PARK,
	output logic [7:0] CTRL_OUT,
	// init monitor
	output logic [2:0] INIT_STAGE,
	output logic INIT_DONE,
	// fabric monitoring
	output logic CTRL_HELD_INDICATOR,
	output logic CTRL_BUS_ACTIVITY,
	// interrupt
	output logic IRQ
);

	// pin synchronisers
	// reset low, so the reset pins read as active until seen
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic dev_rst_pin_n;
	logic test_rst_n;
	logic off_bit;
	logic cal_done;

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
		end else begin
			sync1_reg <= {CALIBRATION_FINISHED, HOLD_FEATURE_OFF_BIT,
				TEST_PORT_RESET_N, DEVICE_RESET_PIN_N};
			sync2_reg <= sync1_reg;
		end
	end

	assign dev_rst_pin_n = sync2_reg[0];
	assign test_rst_n = sync2_reg[1];
	assign off_bit = sync2_reg[2];
	assign cal_done = sync2_reg[3];

	// device reset pin held low restarts the sequence
	// it clears the latch too, so each boot starts awake
	logic dev_rst_active;
	assign dev_rst_active = !dev_rst_pin_n;

	// init sequencer
	scsh_pkg::scsh_seq_t seq_reg;
	scsh_pkg::scsh_seq_t seq_next;
	logic [scsh_pkg::CNT_W-1:0] cnt_reg;
	logic [scsh_pkg::CNT_W-1:0] cnt_next;
	logic phase_end;

	localparam logic [7:0] PHASE_LAST =
		8'(scsh_pkg::INIT_PHASE_CYC - 1);

	// counter idles at zero outside timed phases
	assign phase_end = (cnt_reg == PHASE_LAST);

	// (R1) banks, fabric, hard ip
	always_comb begin
		seq_next = seq_reg;
		cnt_next = phase_end ? '0 : cnt_reg + 8'h01;
		if (dev_rst_active) begin
			seq_next = scsh_pkg::SEQ_BANKS;
			cnt_next = '0;
		end else begin
			unique case (seq_reg)
				scsh_pkg::SEQ_BANKS: begin
					if (phase_end) begin
						seq_next = scsh_pkg::SEQ_FABRIC;
					end
				end
				scsh_pkg::SEQ_FABRIC: begin
					if (phase_end) begin
						seq_next = scsh_pkg::SEQ_HARD_IP;
					end
				end
				scsh_pkg::SEQ_HARD_IP: begin
					if (phase_end) begin
						seq_next = scsh_pkg::SEQ_WAIT_CAL;
					end
				end
				scsh_pkg::SEQ_WAIT_CAL: begin
					cnt_next = '0;
					// (R16) wait for calibration too
					if (cal_done) begin
						seq_next = scsh_pkg::SEQ_DONE;
					end
				end
				scsh_pkg::SEQ_DONE: begin
					cnt_next = '0;
				end
				default: begin
					seq_next = scsh_pkg::SEQ_BANKS;
					cnt_next = '0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			seq_reg <= scsh_pkg::SEQ_BANKS;
			cnt_reg <= '0;
		end else begin
			seq_reg <= seq_next;
			cnt_reg <= cnt_next;
		end
	end

	// one-shot at init completion
	logic init_fin;
	logic auto_set;
	assign init_fin = (seq_reg == scsh_pkg::SEQ_WAIT_CAL) && cal_done &&
		!dev_rst_active;

	// (R12) flash bit 1 switches suspend off
	logic allowed;
	assign allowed = !off_bit;

	// (R13) test port reset must be active
	logic tpr_active;
	assign tpr_active = !test_rst_n;

	// fires once, only in the cycle init completes
	// (R2) auto suspend after init
	assign auto_set = init_fin && allowed && tpr_active;

	// register decode
	logic wr_cmd;
	logic wr_mask;
	logic rd_irq;
	assign wr_cmd = REG_WR && (REG_ADDR == scsh_pkg::ADDR_CMD);
	assign wr_mask = REG_WR && (REG_ADDR == scsh_pkg::ADDR_IRQ_MASK);
	assign rd_irq = REG_RD && (REG_ADDR == scsh_pkg::ADDR_IRQ_STAT);

	logic sw_set;
	logic sw_clear;
	assign sw_set = wr_cmd && REG_WDATA[scsh_pkg::CMD_SET_BIT];
	assign sw_clear = wr_cmd && REG_WDATA[scsh_pkg::CMD_CLEAR_BIT];

	// only a running controller decodes programming loads
	// (R15) programming load clears hold
	logic prog_clear;
	assign prog_clear = PROG_MODE_LOAD && CTRL_RESET_N;

	// latch strobes, active low
	logic hold_latch_set_n;
	logic hold_latch_clear_n;
	// (R6) system register set
	assign hold_latch_set_n = !((sw_set && allowed) || auto_set);
	// (R5) system register clear
	assign hold_latch_clear_n = !(sw_clear || prog_clear || dev_rst_active);

	// redundant hold latch
	logic [scsh_pkg::TMR_COPIES-1:0] copy_q;
	logic hold_vote;

	// a single upset copy is outvoted and rewritten
	// (R17) majority of three
	assign hold_vote = (copy_q[0] & copy_q[1]) | (copy_q[0] & copy_q[2]) |
		(copy_q[1] & copy_q[2]);

	genvar gi;
	generate
		for (gi = 0; gi < scsh_pkg::TMR_COPIES; gi++) begin : g_copy
			// (R3) self-refreshing copy
			scsh_tmr_cell u_cell (
				.clk(CLK_SYS),
				.rst_n(RST_N),
				.set_n(hold_latch_set_n),
				.clear_n(hold_latch_clear_n),
				.vote(hold_vote),
				.q(copy_q[gi])
			);
		end
	endgenerate

	// latch may stay set while parking is gated off
	// (R7) flash allow qualifies the latch
	// (R14) released test reset gates park off
	logic park_req;
	assign park_req = hold_vote && allowed && tpr_active;

	// park and reset ordering
	logic park_reg;
	logic park_next;
	logic rst_n_reg;
	logic rst_n_next;

	// (R8) park first, reset follows
	// on exit reset drops first, parking covers the release
	assign rst_n_next = !(park_reg && park_req);
	// outputs stay parked until reset has released
	assign park_next = park_req || (park_reg && !rst_n_reg);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			park_reg <= 1'b0;
			rst_n_reg <= 1'b1;
		end else begin
			park_reg <= park_next;
			rst_n_reg <= rst_n_next;
		end
	end

	// parked controller outputs and activity
	logic [7:0] out_next;
	logic act_next;
	// (R4) fixed values while held
	assign out_next = park_next ? scsh_pkg::CTRL_PARK_VALUE : CTRL_OUT_RAW;
	// (R10) or of transfer bits
	assign act_next = |CTRL_HTRANS && !park_next;

	// init monitor is not kept during suspend
	logic init_done_next;
	assign init_done_next = (seq_next == scsh_pkg::SEQ_DONE) && !park_next;

	// interrupt events
	logic [scsh_pkg::IRQ_W-1:0] ev;
	logic [scsh_pkg::IRQ_W-1:0] irq_stat_reg;
	logic [scsh_pkg::IRQ_W-1:0] irq_stat_next;
	logic [scsh_pkg::IRQ_W-1:0] irq_mask_reg;
	logic [scsh_pkg::IRQ_W-1:0] irq_mask_next;

	// events from next state, aligned with the output flops
	assign ev[scsh_pkg::EV_ENTER_BIT] = park_next && !park_reg;
	assign ev[scsh_pkg::EV_EXIT_BIT] = !park_next && park_reg;
	assign ev[scsh_pkg::EV_INIT_BIT] = init_fin;

	// read clears, but a same-cycle event is kept
	assign irq_stat_next = (rd_irq ? 3'h0 : irq_stat_reg) | ev;
	assign irq_mask_next = wr_mask ? REG_WDATA[2:0] : irq_mask_reg;

	// (R11) flash bit never readable
	// status word; flash bit deliberately absent
	logic [31:0] status_word;
	always_comb begin
		status_word = 32'h0;
		// (R9) held flag mirrors park
		status_word[scsh_pkg::ST_HELD_BIT] = park_reg;
		status_word[scsh_pkg::ST_ACT_BIT] = CTRL_BUS_ACTIVITY;
		status_word[scsh_pkg::ST_INIT_BIT] = INIT_DONE;
		status_word[scsh_pkg::ST_CAL_BIT] = cal_done;
		status_word[scsh_pkg::ST_RUN_BIT] = rst_n_reg;
		status_word[scsh_pkg::ST_TPR_BIT] = tpr_active;
	end

	// read mux; unmapped and command reads give zero
	logic [31:0] rd_sel;
	assign rd_sel =
		(REG_ADDR == scsh_pkg::ADDR_STATUS) ? status_word :
		(REG_ADDR == scsh_pkg::ADDR_IRQ_STAT) ? {29'h0, irq_stat_reg} :
		(REG_ADDR == scsh_pkg::ADDR_IRQ_MASK) ? {29'h0, irq_mask_reg} :
		32'h0;

	logic [31:0] rdata_next;
	assign rdata_next = REG_RD ? rd_sel : 32'h0;

	// interrupt flops; irq from next values saves a cycle
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			irq_stat_reg <= 3'h0;
			irq_mask_reg <= scsh_pkg::IRQ_MASK_RESET;
			IRQ <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			IRQ <= |(irq_stat_next & irq_mask_next);
		end
	end

	// read data stands one cycle, zero otherwise
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			REG_RDATA <= 32'h0;
		end else begin
			REG_RDATA <= rdata_next;
		end
	end

	// (R8) reset one cycle behind park
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			CTRL_RESET_N <= 1'b1;
			CTRL_PARK <= 1'b0;
		end else begin
			CTRL_RESET_N <= rst_n_next;
			CTRL_PARK <= park_next;
		end
	end

	// (R4) parked port values, registered against glitches
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			CTRL_OUT <= scsh_pkg::CTRL_PARK_VALUE;
			CTRL_BUS_ACTIVITY <= 1'b0;
		end else begin
			CTRL_OUT <= out_next;
			CTRL_BUS_ACTIVITY <= act_next;
		end
	end

	// (R9) copy of park
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			CTRL_HELD_INDICATOR <= 1'b0;
		end else begin
			CTRL_HELD_INDICATOR <= park_next;
		end
	end

	// init monitor flops
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			INIT_STAGE <= scsh_pkg::SEQ_BANKS;
			INIT_DONE <= 1'b0;
		end else begin
			INIT_STAGE <= seq_next;
			INIT_DONE <= init_done_next;
		end
	end

endmodule
`default_nettype wire

// ---- src/scsh_pkg.sv ----
// constants for the controller suspend hold block
// Functional notes
// (R1) After power-on or device reset pin, sequence banks, fabric, hard IP init.
// (R2) With hold enabled, suspend the controller once initialization has finished.
// (R3) Hold state lives in a self-refreshing triple redundant latch.
// (R4) While suspended, controller stays in reset and its outputs are parked.
// (R5) Active-low clear pulse from a system register resets the hold latch.
// (R6) Active-low set pulse from a system register sets the hold latch.
// (R7) Suspend-allow comes from a flash bit and qualifies the latch effect.
// (R8) Park request parks outputs; controller reset asserts only after it.
// (R9) Held indicator is a direct copy of the park request.
// (R10) Activity output is OR of bus transfer bits, low while suspended.
// (R11) Hold-disable flash bit is not readable or writable by user logic.
// (R12) Flash bit 1 disables suspend, 0 enables it.
// (R13) Suspend needs flash allow and active test-port reset; resets reawaken.
// (R14) Releasing test-port reset drops parking and lets the controller run.
// (R15) Programming-mode load pulses latch clear so normal boot follows; the code pulses it only while CTRL_RESET_N is high.
// (R16) Suspend only after init done and calibration done both asserted; the code also parks on a register set command at any stage of init.
// (R17) Latch value is majority of three copies, each rewritten every cycle.
package scsh_pkg;

	// clock
	localparam int CLK_PERIOD_PS = 4000;

	// each init phase lasts this long
	localparam int INIT_PHASE_NS = 40;
	localparam int INIT_PHASE_CYC =
		(INIT_PHASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 8;

	// redundancy
	localparam int TMR_COPIES = 3;

	// controller output port width and parked value
	localparam int CTRL_OUT_W = 8;
	localparam logic [7:0] CTRL_PARK_VALUE = 8'h00;

	// register port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

	// command bits
	localparam int CMD_SET_BIT = 0;
	localparam int CMD_CLEAR_BIT = 1;

	// status bits
	localparam int ST_HELD_BIT = 0;
	localparam int ST_ACT_BIT = 1;
	localparam int ST_INIT_BIT = 2;
	localparam int ST_CAL_BIT = 3;
	localparam int ST_RUN_BIT = 4;
	localparam int ST_TPR_BIT = 5;

	// interrupt events
	localparam int IRQ_W = 3;
	localparam int EV_ENTER_BIT = 0;
	localparam int EV_EXIT_BIT = 1;
	localparam int EV_INIT_BIT = 2;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	// init sequencer
	typedef enum logic [2:0] {
		SEQ_BANKS = 3'b000,
		SEQ_FABRIC = 3'b001,
		SEQ_HARD_IP = 3'b010,
		SEQ_WAIT_CAL = 3'b011,
		SEQ_DONE = 3'b100
	} scsh_seq_t;

endpackage

// ---- src/scsh_tmr_cell.sv ----
// one self-refreshing copy of the redundant hold latch
`timescale 1ns/1ps
`default_nettype none
module scsh_tmr_cell (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// latch controls, active low
	input wire logic set_n,
	input wire logic clear_n,
	// majority of all copies
	input wire logic vote,
	// stored copy
	output logic q
);
	logic q_next;

	// clear beats set, so a programming load wins whenever CTRL_RESET_N is high
	assign q_next = !clear_n ? 1'b0 : (!set_n ? 1'b1 : vote);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= 1'b0;
		end else begin
			q <= q_next;
		end
	end
endmodule
`default_nettype wire

// ---- bench/scsh_chk.sv ----
// port assertions for the suspend hold block
`timescale 1ns/1ps
`default_nettype none
module scsh_chk (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// pins
	input wire logic TEST_PORT_RESET_N,
	input wire logic HOLD_FEATURE_OFF_BIT,
	input wire logic [1:0] CTRL_HTRANS,
	input wire logic [7:0] CTRL_OUT_RAW,
	// outputs
	input wire logic CTRL_RESET_N,
	input wire logic CTRL_PARK,
	input wire logic [7:0] CTRL_OUT,
	input wire logic [2:0] INIT_STAGE,
	input wire logic CTRL_HELD_INDICATOR,
	input wire logic CTRL_BUS_ACTIVITY
);
	wire logic htr_any = |CTRL_HTRANS;
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	property p_held;
		CTRL_HELD_INDICATOR == CTRL_PARK;
	endproperty
	a_held: assert property (p_held) else $error("held differs");
	property p_parked;
		CTRL_PARK && $past(CTRL_PARK) |->
			CTRL_OUT == scsh_pkg::CTRL_PARK_VALUE && !CTRL_BUS_ACTIVITY;
	endproperty
	a_parked: assert property (p_parked) else $error("not parked");
	// first cycle after reset still shows reset values
	property p_follow;
		$past(RST_N) && !CTRL_PARK && !$past(CTRL_PARK) |->
			CTRL_OUT == $past(CTRL_OUT_RAW) &&
			CTRL_BUS_ACTIVITY == $past(htr_any);
	endproperty
	a_follow: assert property (p_follow) else $error("bad follow");
	property p_rst_late;
		$fell(CTRL_RESET_N) |-> $past(CTRL_PARK);
	endproperty
	a_rst_late: assert property (p_rst_late) else $error("early reset");
	property p_rst_next;
		$rose(CTRL_PARK) |=> $fell(CTRL_RESET_N);
	endproperty
	a_rst_next: assert property (p_rst_next) else $error("no reset");
	property p_release;
		$rose(CTRL_RESET_N) |=> $fell(CTRL_PARK);
	endproperty
	a_release: assert property (p_release) else $error("park kept");
	property p_trst;
		TEST_PORT_RESET_N [*6] |-> !CTRL_PARK;
	endproperty
	a_trst: assert property (p_trst) else $error("park no trst");
	property p_flash;
		HOLD_FEATURE_OFF_BIT [*6] |-> !CTRL_PARK;
	endproperty
	a_flash: assert property (p_flash) else $error("park flash off");
	property p_stage;
		$rose(CTRL_PARK) |-> INIT_STAGE == 3'h4;
	endproperty
	a_stage: assert property (p_stage) else $error("park early");
endmodule
bind scsh_top scsh_chk i_scsh_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
	.TEST_PORT_RESET_N(TEST_PORT_RESET_N),
	.HOLD_FEATURE_OFF_BIT(HOLD_FEATURE_OFF_BIT),
	.CTRL_HTRANS(CTRL_HTRANS), .CTRL_OUT_RAW(CTRL_OUT_RAW),
	.CTRL_RESET_N(CTRL_RESET_N), .CTRL_PARK(CTRL_PARK),
	.CTRL_OUT(CTRL_OUT), .INIT_STAGE(INIT_STAGE),
	.CTRL_HELD_INDICATOR(CTRL_HELD_INDICATOR),
	.CTRL_BUS_ACTIVITY(CTRL_BUS_ACTIVITY));
`default_nettype wire

// ---- bench/scsh_fabric_mon.sv ----
// fabric logic watching the controller status
`timescale 1ns/1ps
`default_nettype none
module scsh_fabric_mon (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// status in
	input wire logic held,
	input wire logic activity,
	input wire logic init_done,
	// observations
	output logic init_kept,
	output logic act_in_hold
);
	logic held_d;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			held_d <= 1'b0;
			init_kept <= 1'b0;
			act_in_hold <= 1'b0;
		end else begin
			held_d <= held;
			init_kept <= init_kept | init_done;
			act_in_hold <= act_in_hold | (held & held_d & activity);
		end
	end
endmodule
`default_nettype wire

// ---- bench/test_scsh_top.sv ----
// self-checking bench for the suspend hold block
`timescale 1ns/1ps
`default_nettype none
module test_scsh_top;
	logic CLK_SYS = 1'b0;
	logic RST_N = 1'b0;
	logic dev_n = 1'b1;
	logic trst_n = 1'b0;
	logic flash_off = 1'b0;
	logic cal = 1'b0;
	logic prog = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [1:0] htrans = 2'b10;
	logic [7:0] raw = 8'h5a;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] d;
	wire logic [31:0] rdata;
	wire logic [7:0] out;
	wire logic [2:0] stage;
	wire logic rst_o, park, held, act, idone, irq, kept, bad;
	int error_cnt = 0;
	int total_checks = 0;
	always #2 CLK_SYS = ~CLK_SYS;
	scsh_top i_scsh_top (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
		.DEVICE_RESET_PIN_N(dev_n), .TEST_PORT_RESET_N(trst_n),
		.HOLD_FEATURE_OFF_BIT(flash_off), .CALIBRATION_FINISHED(cal),
		.CTRL_HTRANS(htrans), .CTRL_OUT_RAW(raw), .PROG_MODE_LOAD(prog),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
		.REG_RDATA(rdata), .CTRL_RESET_N(rst_o), .CTRL_PARK(park),
		.CTRL_OUT(out), .INIT_STAGE(stage), .INIT_DONE(idone),
		.CTRL_HELD_INDICATOR(held), .CTRL_BUS_ACTIVITY(act), .IRQ(irq));
	scsh_fabric_mon i_scsh_fabric_mon (.clk(CLK_SYS), .rst_n(RST_N),
		.held(held), .activity(act), .init_done(idone),
		.init_kept(kept), .act_in_hold(bad));
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk1(input string n, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %b got %b", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge CLK_SYS);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge CLK_SYS);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge CLK_SYS);
		addr <= a;
		rd <= 1'b1;
		@(posedge CLK_SYS);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// bounded wait, one cycle at a time
	task automatic wait_park(input logic v);
		int i;
		i = 0;
		while (park !== v && i < 400) begin
			cyc(1);
			i++;
		end
		chk1("park", v, park);
	endtask
	task automatic wrap_up;
		if (error_cnt == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic t_boot;
		rd_reg(scsh_pkg::ADDR_IRQ_MASK);
		chk("mask", 32'h0, d);
		rd_reg(8'h10);
		chk("unmapped", 32'h0, d);
		cyc(60);
		chk("stage", 32'h3, 32'(stage));
		chk1("park", 1'b0, park);
	endtask
	task automatic t_auto;
		@(posedge CLK_SYS);
		cal <= 1'b1;
		wait_park(1'b1);
		chk1("held", 1'b1, held);
		chk("stage", 32'h4, 32'(stage));
		chk1("init_done", 1'b0, idone);
		cyc(1);
		chk1("ctrl_rst", 1'b0, rst_o);
		chk("out", 32'h0, 32'(out));
		chk1("act", 1'b0, act);
		rd_reg(scsh_pkg::ADDR_STATUS);
		chk("status", 32'h29, d);
		cyc(1);
		chk("rdata_idle", 32'h0, rdata);
		rd_reg(scsh_pkg::ADDR_IRQ_STAT);
		chk("irq_stat", 32'h5, d);
		chk1("irq", 1'b0, irq);
		rd_reg(scsh_pkg::ADDR_IRQ_STAT);
		chk("irq_stat", 32'h0, d);
	endtask
	task automatic t_exit;
		wr_reg(scsh_pkg::ADDR_IRQ_MASK, 32'h2);
		wr_reg(scsh_pkg::ADDR_CMD, 32'h2);
		cyc(1);
		chk1("ctrl_rst", 1'b1, rst_o);
		chk1("park", 1'b1, park);
		cyc(1);
		chk1("park", 1'b0, park);
		cyc(3);
		chk1("irq", 1'b1, irq);
		chk("out", 32'h5a, 32'(out));
		chk1("act", 1'b1, act);
		chk1("init_done", 1'b1, idone);
		chk1("kept", 1'b1, kept);
		rd_reg(scsh_pkg::ADDR_IRQ_STAT);
		chk("irq_stat", 32'h2, d);
		cyc(1);
		chk1("irq", 1'b0, irq);
	endtask
	task automatic t_set;
		wr_reg(scsh_pkg::ADDR_CMD, 32'h1);
		cyc(1);
		chk1("park", 1'b1, park);
		chk1("ctrl_rst", 1'b1, rst_o);
		cyc(1);
		chk1("ctrl_rst", 1'b0, rst_o);
	endtask
	// latch stays set, so only the pulse keeps park away later
	task automatic t_trst;
		@(posedge CLK_SYS);
		trst_n <= 1'b1;
		wait_park(1'b0);
		chk1("ctrl_rst", 1'b1, rst_o);
		@(posedge CLK_SYS);
		prog <= 1'b1;
		@(posedge CLK_SYS);
		prog <= 1'b0;
		trst_n <= 1'b0;
		cyc(10);
		chk1("park", 1'b0, park);
	endtask
	task automatic t_flash;
		@(posedge CLK_SYS);
		flash_off <= 1'b1;
		cyc(4);
		wr_reg(scsh_pkg::ADDR_CMD, 32'h1);
		cyc(8);
		chk1("park", 1'b0, park);
		rd_reg(scsh_pkg::ADDR_STATUS);
		chk("status", 32'h3e, d);
		@(posedge CLK_SYS);
		flash_off <= 1'b0;
		cyc(4);
	endtask
	task automatic t_devrst;
		@(posedge CLK_SYS);
		dev_n <= 1'b0;
		cyc(4);
		@(posedge CLK_SYS);
		dev_n <= 1'b1;
		cyc(4);
		chk("stage", 32'h0, 32'(stage));
		wait_park(1'b1);
		chk1("act_in_hold", 1'b0, bad);
	endtask
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		t_boot();
		t_auto();
		t_exit();
		t_set();
		t_trst();
		t_flash();
		t_devrst();
		wrap_up();
	end
endmodule
`default_nettype wire
